/* File: rtl/ocrx_pkg.sv */
// Package: constants, register map and helpers for the output control receive decoder
package ocrx_pkg;

	// ==========================================================
	// Message identity and layout
	localparam logic [17:0] OCRX_PGN_DEFAULT = 18'h0FF80;	// Group number 65408
	localparam logic [3:0]  OCRX_FRAME_LEN   = 4'h8;
	localparam int          OCRX_CHANNELS    = 8;
	localparam logic [7:0]  OCRX_CHEN_RESET  = 8'h03;	// Only channels 0 and 1 on
	localparam int          OCRX_MY_CHANNEL  = 0;

	// Zero-based payload byte positions
	localparam int OCRX_B_CMD1 = 0;
	localparam int OCRX_B_CMD2 = 1;
	localparam int OCRX_B_FB1  = 2;
	localparam int OCRX_B_FB2  = 3;
	localparam int OCRX_B_EN1  = 4;
	localparam int OCRX_B_EN2  = 5;
	localparam int OCRX_B_OV1  = 6;
	localparam int OCRX_B_OV2  = 7;

	// ==========================================================
	// State field codes
	localparam logic [7:0] OCRX_ST_OFF = 8'h00;
	localparam logic [7:0] OCRX_ST_ON  = 8'h01;
	localparam logic [7:0] OCRX_ST_ERR = 8'h02;

	// ==========================================================
	// Scaling: results in tenths, 4 tenths per bit, ceiling 100.0
	localparam logic [9:0] OCRX_SCALE_MUL = 10'h004;
	localparam logic [9:0] OCRX_SCALE_MAX = 10'h3E8;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OCRX_REG_CHEN  = 8'h00;
	localparam logic [7:0] OCRX_REG_PGN   = 8'h04;
	localparam logic [7:0] OCRX_REG_STAT  = 8'h08;
	localparam logic [7:0] OCRX_REG_CMD   = 8'h0C;
	localparam logic [7:0] OCRX_REG_FB    = 8'h10;
	localparam logic [7:0] OCRX_REG_STATE = 8'h14;

	function automatic logic [9:0] ocrx_scale(input logic [7:0] raw);
		logic [9:0] w;
		w = {2'h0, raw} * OCRX_SCALE_MUL;
		ocrx_scale = (w > OCRX_SCALE_MAX) ? OCRX_SCALE_MAX : w;
	endfunction

	function automatic logic [7:0] ocrx_byte(input logic [63:0] data, input int idx);
		ocrx_byte = data[8*idx +: 8];
	endfunction

endpackage

/* File: rtl/ocrx_frame_if.sv */
// Interface: received frame and acceptance between decoder core and frame filter
`timescale 1ns/1ps
interface ocrx_frame_if;
	logic        valid;
	logic [17:0] pgn;
	logic [3:0]  len;
	logic [63:0] data;
	logic [17:0] cfgPgn;
	logic        chanOn;
	logic        match;

	modport filt (
		input  valid, pgn, len, data, cfgPgn, chanOn,
		output match
	);
	modport core (
		output valid, pgn, len, data, cfgPgn, chanOn,
		input  match
	);
endinterface

/* File: rtl/ocrx_frame_filter.sv */
// Frame filter: accepts frames that carry the configured group number
`timescale 1ns/1ps
module ocrx_frame_filter
	import ocrx_pkg::*;
(
	input  wire logic   ref_clk,	// System clock
	input  wire logic   reset,		// Synchronous reset, high
	ocrx_frame_if.filt  fr			// Frame and acceptance
);

	// ==========================================================
	// Acceptance
	// Short frames are dropped rather than decoded with stale bytes
	wire pgnHit = (fr.pgn == fr.cfgPgn);
	wire lenOk  = (fr.len >= OCRX_FRAME_LEN);
	assign fr.match = fr.valid && fr.chanOn && pgnHit && lenOk;

	// ==========================================================
	// Checks
	property p_match_pgn;
		@(posedge ref_clk) disable iff (reset)
		fr.match |-> (fr.pgn == fr.cfgPgn) && fr.chanOn && fr.valid;
	endproperty
	a_match_pgn: assert property (p_match_pgn)
		else $error("Frame accepted with wrong group number or channel off");

	property p_short_drop;
		@(posedge ref_clk) disable iff (reset)
		(fr.valid && (fr.len < OCRX_FRAME_LEN)) |-> !fr.match;
	endproperty
	a_short_drop: assert property (p_short_drop)
		else $error("Short frame was accepted");

endmodule

/* File: rtl/ocrx_decoder.sv */
// Output control receive decoder with AHB-Lite register slave
// How it works
// - Accept the output control message on group number 65408 by default.
// - Byte 1 is output one command, byte 2 output two command.
// - Byte 3 is output one feedback, byte 4 output two feedback.
// - Byte 5 is output one enable, byte 6 output two enable.
// - Byte 7 is output one override, byte 8 output two override.
// - Command scales 0.4 percent per bit, zero offset, 0 to 100 percent.
// - Feedback scales 0.4 units per bit, zero offset, 0 to 100.0.
// - Enable: 00 off, 01 on, 02 error; 03 and above ignored.
// - Override: 00 off, 01 on, 02 error; 03 and above ignored.
// - Only the first two receive channels are enabled at reset.
// - The accepted group number is configurable, not fixed.
// - No trouble-code numbers are attached to received values.
`timescale 1ns/1ps
module ocrx_decoder
	import ocrx_pkg::*;
(
	input  wire logic        ref_clk,	// System clock, 250 MHz
	input  wire logic        reset,		// Synchronous reset, high
	input  wire logic        hsel,		// AHB slave select
	input  wire logic [31:0] haddr,		// AHB address
	input  wire logic [1:0]  htrans,	// AHB transfer type
	input  wire logic        hwrite,	// AHB write
	input  wire logic [2:0]  hsize,		// AHB size, word only
	input  wire logic [31:0] hwdata,	// AHB write data
	input  wire logic        hready,	// AHB bus ready
	output logic             hreadyout,	// AHB slave ready
	output logic             hresp,		// AHB response, always OKAY
	output logic [31:0]      hrdata,	// AHB read data
	input  wire logic        rxValid,	// Received frame strobe
	input  wire logic [17:0] rxPgn,		// Received group number
	input  wire logic [3:0]  rxLen,		// Received byte count
	input  wire logic [63:0] rxData,	// Payload, byte 1 in bits 7:0
	output logic [9:0]       out1Cmd,	// Output one command, tenths of percent
	output logic [9:0]       out2Cmd,	// Output two command, tenths of percent
	output logic [9:0]       out1Fb,	// Output one feedback, tenths
	output logic [9:0]       out2Fb,	// Output two feedback, tenths
	output logic [1:0]       out1En,	// Output one enable state
	output logic [1:0]       out2En,	// Output two enable state
	output logic [1:0]       out1Ovr,	// Output one override state
	output logic [1:0]       out2Ovr,	// Output two override state
	output logic             dataValid,	// A message has been decoded
	output logic             update		// One-cycle pulse on new values
);

	// ==========================================================
	// Frame filter
	ocrx_frame_if fr ();

	logic [OCRX_CHANNELS-1:0] chanEn_r;
	logic [17:0]              cfgPgn_r;

	assign fr.valid  = rxValid;
	assign fr.pgn    = rxPgn;
	assign fr.len    = rxLen;
	assign fr.data   = rxData;
	assign fr.cfgPgn = cfgPgn_r;
	assign fr.chanOn = chanEn_r[OCRX_MY_CHANNEL];

	ocrx_frame_filter u_filter (
		.ref_clk (ref_clk),
		.reset   (reset),
		.fr      (fr.filt)
	);

	// ==========================================================
	// Field extraction
	// Bytes carry no trouble-code tags; only values leave this block
	wire [7:0] cmd1Raw = ocrx_byte(fr.data, OCRX_B_CMD1);
	wire [7:0] cmd2Raw = ocrx_byte(fr.data, OCRX_B_CMD2);
	wire [7:0] fb1Raw  = ocrx_byte(fr.data, OCRX_B_FB1);
	wire [7:0] fb2Raw  = ocrx_byte(fr.data, OCRX_B_FB2);
	wire [7:0] en1Raw  = ocrx_byte(fr.data, OCRX_B_EN1);
	wire [7:0] en2Raw  = ocrx_byte(fr.data, OCRX_B_EN2);
	wire [7:0] ov1Raw  = ocrx_byte(fr.data, OCRX_B_OV1);
	wire [7:0] ov2Raw  = ocrx_byte(fr.data, OCRX_B_OV2);

	// Codes above error keep the previous state
	wire en1Ok = (en1Raw <= OCRX_ST_ERR);
	wire en2Ok = (en2Raw <= OCRX_ST_ERR);
	wire ov1Ok = (ov1Raw <= OCRX_ST_ERR);
	wire ov2Ok = (ov2Raw <= OCRX_ST_ERR);

	// ==========================================================
	// Decoded value registers
	logic [9:0]  cmd1_r, cmd2_r, fb1_r, fb2_r;
	logic [1:0]  en1_r, en2_r, ov1_r, ov2_r;
	logic        valid_r, update_r;
	logic [15:0] msgCount_r;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cmd1_r <= 10'h000;
			cmd2_r <= 10'h000;
			fb1_r  <= 10'h000;
			fb2_r  <= 10'h000;
			en1_r  <= 2'h0;
			en2_r  <= 2'h0;
			ov1_r  <= 2'h0;
			ov2_r  <= 2'h0;
		end else if (fr.match) begin
			cmd1_r <= ocrx_scale(cmd1Raw);
			cmd2_r <= ocrx_scale(cmd2Raw);
			fb1_r  <= ocrx_scale(fb1Raw);
			fb2_r  <= ocrx_scale(fb2Raw);
			if (en1Ok) en1_r <= en1Raw[1:0];
			if (en2Ok) en2_r <= en2Raw[1:0];
			if (ov1Ok) ov1_r <= ov1Raw[1:0];
			if (ov2Ok) ov2_r <= ov2Raw[1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			valid_r    <= 1'b0;
			update_r   <= 1'b0;
			msgCount_r <= 16'h0000;
		end else begin
			update_r <= fr.match;
			if (fr.match) begin
				valid_r    <= 1'b1;
				msgCount_r <= msgCount_r + 16'h0001;
			end
		end
	end

	assign out1Cmd   = cmd1_r;
	assign out2Cmd   = cmd2_r;
	assign out1Fb    = fb1_r;
	assign out2Fb    = fb2_r;
	assign out1En    = en1_r;
	assign out2En    = en2_r;
	assign out1Ovr   = ov1_r;
	assign out2Ovr   = ov2_r;
	assign dataValid = valid_r;
	assign update    = update_r;

	// ==========================================================
	// AHB-Lite slave
	// Zero wait states; read data is fetched in the address phase so it
	// comes from a flop, at the cost of not seeing a write one beat earlier
	logic       wrPend_r;
	logic [7:0] wrAddr_r;
	logic [31:0] rdata_r;

	wire        addrPhase = hsel && htrans[1] && hready;
	wire [7:0]  regAddr   = haddr[7:0];
	wire [31:0] stateWord = {24'h000000, ov2_r, ov1_r, en2_r, en1_r};
	wire [31:0] rdMux =
		(regAddr == OCRX_REG_CHEN)  ? {{(32-OCRX_CHANNELS){1'b0}}, chanEn_r} :
		(regAddr == OCRX_REG_PGN)   ? {14'h0000, cfgPgn_r} :
		(regAddr == OCRX_REG_STAT)  ? {15'h0000, valid_r, msgCount_r} :
		(regAddr == OCRX_REG_CMD)   ? {6'h00, cmd2_r, 6'h00, cmd1_r} :
		(regAddr == OCRX_REG_FB)    ? {6'h00, fb2_r, 6'h00, fb1_r} :
		(regAddr == OCRX_REG_STATE) ? stateWord : 32'h00000000;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
			rdata_r  <= 32'h00000000;
		end else begin
			wrPend_r <= addrPhase && hwrite;
			if (addrPhase) begin
				wrAddr_r <= regAddr;
				rdata_r  <= hwrite ? 32'h00000000 : rdMux;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			chanEn_r <= OCRX_CHEN_RESET;
			cfgPgn_r <= OCRX_PGN_DEFAULT;
		end else if (wrPend_r) begin
			if (wrAddr_r == OCRX_REG_CHEN)
				chanEn_r <= hwdata[OCRX_CHANNELS-1:0];
			else if (wrAddr_r == OCRX_REG_PGN)
				cfgPgn_r <= hwdata[17:0];
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;

	// ==========================================================
	// Checks
	property p_reset_chen;
		@(posedge ref_clk)
		reset |=> (chanEn_r == OCRX_CHEN_RESET) && (cfgPgn_r == OCRX_PGN_DEFAULT);
	endproperty
	a_reset_chen: assert property (p_reset_chen)
		else $error("Channel enables or group number wrong after reset");

	property p_cmd_bytes;
		@(posedge ref_clk) disable iff (reset)
		fr.match |=> (out1Cmd == ocrx_scale($past(cmd1Raw)))
			&& (out2Cmd == ocrx_scale($past(cmd2Raw)));
	endproperty
	a_cmd_bytes: assert property (p_cmd_bytes)
		else $error("Command values not taken from bytes 1 and 2");

	property p_cmd_scale;
		@(posedge ref_clk) disable iff (reset)
		(fr.match && (cmd1Raw == 8'hFA))
			|=> (out1Cmd == OCRX_SCALE_MAX) ##1 (out1Cmd <= OCRX_SCALE_MAX);
	endproperty
	a_cmd_scale: assert property (p_cmd_scale)
		else $error("Full-scale command byte not scaled to 100 percent");

	property p_fb_bytes;
		@(posedge ref_clk) disable iff (reset)
		fr.match |=> (out1Fb == ocrx_scale($past(fb1Raw)))
			&& (out2Fb == ocrx_scale($past(fb2Raw)));
	endproperty
	a_fb_bytes: assert property (p_fb_bytes)
		else $error("Feedback values not taken from bytes 3 and 4 at 0.4 per bit");

	property p_en_take;
		@(posedge ref_clk) disable iff (reset)
		(fr.match && en1Ok) |=> (out1En == $past(en1Raw[1:0])) && update;
	endproperty
	a_en_take: assert property (p_en_take)
		else $error("Output one enable not taken from byte 5");

	property p_en_ignore;
		@(posedge ref_clk) disable iff (reset)
		(fr.match && !en2Ok) |=> $stable(out2En);
	endproperty
	a_en_ignore: assert property (p_en_ignore)
		else $error("Ignored enable code changed output two enable");

	property p_ovr_take;
		@(posedge ref_clk) disable iff (reset)
		fr.match |=> ($past(ov1Ok) ? (out1Ovr == $past(ov1Raw[1:0])) : $stable(out1Ovr));
	endproperty
	a_ovr_take: assert property (p_ovr_take)
		else $error("Output one override not decoded from byte 7");

	property p_hold;
		@(posedge ref_clk) disable iff (reset)
		!fr.match |=> $stable(out1Cmd) && $stable(out2Fb) && $stable(out2Ovr) && !update;
	endproperty
	a_hold: assert property (p_hold)
		else $error("Decoded value changed without a matching message");

	// ==========================================================
	// Further checks, both outputs, valid and update, and register writes
	property p_en2_take;
		@(posedge ref_clk) disable iff (reset)
		(fr.match && en2Ok) |=> (out2En == $past(en2Raw[1:0]));
	endproperty
	a_en2_take: assert property (p_en2_take)
		else $error("Output two enable not taken from byte 6");

	property p_en1_ignore;
		@(posedge ref_clk) disable iff (reset)
		(fr.match && !en1Ok) |=> $stable(out1En);
	endproperty
	a_en1_ignore: assert property (p_en1_ignore)
		else $error("Ignored enable code changed output one enable");

	property p_ovr2_take;
		@(posedge ref_clk) disable iff (reset)
		fr.match |=> ($past(ov2Ok) ? (out2Ovr == $past(ov2Raw[1:0])) : $stable(out2Ovr));
	endproperty
	a_ovr2_take: assert property (p_ovr2_take)
		else $error("Output two override not decoded from byte 8");

	property p_cmd2_clamp;
		@(posedge ref_clk) disable iff (reset)
		(fr.match && (cmd2Raw > 8'hFA)) |=> (out2Cmd == OCRX_SCALE_MAX);
	endproperty
	a_cmd2_clamp: assert property (p_cmd2_clamp)
		else $error("Command above full scale not held at 100 percent");

	property p_fb_clamp;
		@(posedge ref_clk) disable iff (reset)
		(fr.match && (fb1Raw > 8'hFA)) |=> (out1Fb == OCRX_SCALE_MAX);
	endproperty
	a_fb_clamp: assert property (p_fb_clamp)
		else $error("Feedback above full scale not held at 100.0");

	property p_valid_sticky;
		@(posedge ref_clk) disable iff (reset)
		dataValid |=> dataValid;
	endproperty
	a_valid_sticky: assert property (p_valid_sticky)
		else $error("Data valid dropped without reset");

	property p_update_match;
		@(posedge ref_clk) disable iff (reset)
		fr.match |=> update && dataValid;
	endproperty
	a_update_match: assert property (p_update_match)
		else $error("Accepted message gave no update pulse");

	property p_hold_rest;
		@(posedge ref_clk) disable iff (reset)
		!fr.match |=> $stable(out2Cmd) && $stable(out1Fb) && $stable(out1En)
			&& $stable(out2En) && $stable(out1Ovr);
	endproperty
	a_hold_rest: assert property (p_hold_rest)
		else $error("Decoded value changed without a matching message");

	property p_wr_chen;
		@(posedge ref_clk) disable iff (reset)
		(wrPend_r && (wrAddr_r == OCRX_REG_CHEN)) |=> (chanEn_r == $past(hwdata[OCRX_CHANNELS-1:0]));
	endproperty
	a_wr_chen: assert property (p_wr_chen)
		else $error("Channel enable write did not land");

	property p_wr_pgn;
		@(posedge ref_clk) disable iff (reset)
		(wrPend_r && (wrAddr_r == OCRX_REG_PGN)) |=> (cfgPgn_r == $past(hwdata[17:0]));
	endproperty
	a_wr_pgn: assert property (p_wr_pgn)
		else $error("Group number write did not land");

endmodule

/* File: tb/ocrx_sender.sv */
// Partner model: a network node that sends output control frames
`timescale 1ns/1ps
module ocrx_sender (
	input  wire logic   ref_clk,	// System clock
	output logic        rxValid,	// Frame strobe
	output logic [17:0] rxPgn,		// Group number
	output logic [3:0]  rxLen,		// Byte count
	output logic [63:0] rxData		// Payload, byte 1 lowest
);
	initial begin
		rxValid = 1'b0;
		rxPgn   = 18'h00000;
		rxLen   = 4'h0;
		rxData  = 64'h0;
	end

	// =================================================
	// Frame send; hold keeps the strobe up for a following frame
	task automatic send(input logic [17:0] pgn, input logic [3:0] len,
			input logic [63:0] data, input logic hold);
		@(posedge ref_clk);
		rxValid <= 1'b1;
		rxPgn   <= pgn;
		rxLen   <= len;
		rxData  <= data;
		if (!hold) begin
			@(posedge ref_clk);
			rxValid <= 1'b0;
			// Stale lines inverted so no one relies on leftovers
			rxPgn   <= ~pgn;
			rxLen   <= ~len;
			rxData  <= ~data;
		end
	endtask
endmodule

/* File: tb/output_control_rx_decoder_test.sv */
// Testbench: scenarios for the output control receive decoder
`timescale 1ns/1ps
module output_control_rx_decoder_test
	import ocrx_pkg::*;
;
	localparam logic [17:0] DEF = 18'h0FF80;	// 65408

	logic        ref_clk;
	logic        reset  = 1'b1;
	logic        hsel   = 1'b0;
	logic [31:0] haddr  = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize  = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout, hresp, rxValid, dataValid, update;
	logic [31:0] hrdata, rdat;
	logic [17:0] rxPgn;
	logic [3:0]  rxLen;
	logic [63:0] rxData;
	logic [9:0]  out1Cmd, out2Cmd, out1Fb, out2Fb;
	logic [1:0]  out1En, out2En, out1Ovr, out2Ovr;
	logic [9:0]  eCmd [2] = '{10'h0, 10'h0};
	logic [9:0]  eFb  [2] = '{10'h0, 10'h0};
	logic [1:0]  eEn  [2] = '{2'h0, 2'h0};
	logic [1:0]  eOv  [2] = '{2'h0, 2'h0};
	logic        eVal = 1'b0;
	logic [15:0] eCnt = 16'h0;
	int          errorCnt = 0;
	int          samplesChecked = 0;

	ocrx_decoder i_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rxValid(rxValid), .rxPgn(rxPgn), .rxLen(rxLen), .rxData(rxData),
		.out1Cmd(out1Cmd), .out2Cmd(out2Cmd), .out1Fb(out1Fb), .out2Fb(out2Fb),
		.out1En(out1En), .out2En(out2En), .out1Ovr(out1Ovr), .out2Ovr(out2Ovr),
		.dataValid(dataValid), .update(update));
	ocrx_sender i_snd (.ref_clk(ref_clk), .rxValid(rxValid), .rxPgn(rxPgn),
		.rxLen(rxLen), .rxData(rxData));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// =================================================
	// Helpers
	function automatic logic [9:0] scl(input logic [7:0] b);
		return (b > 8'hFA) ? 10'h3E8 : {b, 2'h0};
	endfunction
	// Codes 3 and above keep the previous state
	function automatic logic [1:0] st(input logic [7:0] b, input logic [1:0] prev);
		return (b < 8'h03) ? b[1:0] : prev;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errorCnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge ref_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({30'h0, hreadyout, hresp}, 32'h00000002);
	endtask

	task automatic expUpd(input logic [63:0] d);
		for (int i = 0; i < 2; i++) begin
			eCmd[i] = scl(d[8*i +: 8]);
			eFb[i]  = scl(d[16+8*i +: 8]);
			eEn[i]  = st(d[32+8*i +: 8], eEn[i]);
			eOv[i]  = st(d[48+8*i +: 8], eOv[i]);
		end
		eVal = 1'b1;
		eCnt = eCnt + 16'h0001;
	endtask

	task automatic chkOuts;
		chk({22'h0, out1Cmd}, {22'h0, eCmd[0]});
		chk({22'h0, out2Cmd}, {22'h0, eCmd[1]});
		chk({22'h0, out1Fb}, {22'h0, eFb[0]});
		chk({22'h0, out2Fb}, {22'h0, eFb[1]});
		chk({30'h0, out1En}, {30'h0, eEn[0]});
		chk({30'h0, out2En}, {30'h0, eEn[1]});
		chk({30'h0, out1Ovr}, {30'h0, eOv[0]});
		chk({30'h0, out2Ovr}, {30'h0, eOv[1]});
		chk({31'h0, dataValid}, {31'h0, eVal});
	endtask

	task automatic frame(input logic [17:0] p, input logic [3:0] l, input logic [63:0] d,
			input logic acc);
		i_snd.send(p, l, d, 1'b0);
		if (acc) begin
			expUpd(d);
		end
		#1;
		chk({31'h0, update}, {31'h0, acc});
		chkOuts;
		@(posedge ref_clk);
		#1;
		chk({31'h0, update}, 32'h0);
	endtask

	// =================================================
	// Scenarios
	task automatic tReset;
		#1;
		chkOuts;
		ahb(1'b0, OCRX_REG_CHEN, 32'h0, rdat);
		chk(rdat, 32'h00000003);
		ahb(1'b0, OCRX_REG_PGN, 32'h0, rdat);
		chk(rdat, {14'h0, DEF});
		ahb(1'b0, 8'h40, 32'h0, rdat);
		chk(rdat, 32'h0);
	endtask

	task automatic tFields;
		frame(DEF, 4'h8, 64'h0201010040190A05, 1'b1);
		frame(DEF, 4'h8, 64'h0100000200FFFBFA, 1'b1);
		frame(DEF, 4'h8, 64'hFF0303FF00000001, 1'b1);
	endtask

	task automatic tRefuse;
		frame(18'h0FF81, 4'h8, 64'h0000000011111111, 1'b0);
		frame(DEF, 4'h7, 64'h0000000022222222, 1'b0);
		ahb(1'b1, OCRX_REG_CHEN, 32'h00000002, rdat);
		ahb(1'b0, OCRX_REG_CHEN, 32'h0, rdat);
		chk(rdat, 32'h00000002);
		frame(DEF, 4'h8, 64'h0000000033333333, 1'b0);
		ahb(1'b1, OCRX_REG_CHEN, 32'h00000003, rdat);
	endtask

	task automatic tRemap;
		ahb(1'b1, OCRX_REG_PGN, 32'h0000FF81, rdat);
		ahb(1'b0, OCRX_REG_PGN, 32'h0, rdat);
		chk(rdat, 32'h0000FF81);
		frame(18'h0FF81, 4'h8, 64'h0101010144444444, 1'b1);
		frame(DEF, 4'h8, 64'h0000000055555555, 1'b0);
		ahb(1'b1, OCRX_REG_PGN, {14'h0, DEF}, rdat);
	endtask

	task automatic tBurst;
		i_snd.send(DEF, 4'h8, 64'h0202020210203040, 1'b1);
		expUpd(64'h0202020210203040);
		frame(DEF, 4'h8, 64'h0101010350607080, 1'b1);
		ahb(1'b0, OCRX_REG_STAT, 32'h0, rdat);
		chk(rdat, {15'h0, eVal, eCnt});
		ahb(1'b1, OCRX_REG_CMD, 32'hFFFFFFFF, rdat);
		ahb(1'b0, OCRX_REG_CMD, 32'h0, rdat);
		chk(rdat, {6'h0, eCmd[1], 6'h0, eCmd[0]});
		ahb(1'b0, OCRX_REG_FB, 32'h0, rdat);
		chk(rdat, {6'h0, eFb[1], 6'h0, eFb[0]});
		ahb(1'b0, OCRX_REG_STATE, 32'h0, rdat);
		chk(rdat, {24'h0, eOv[1], eOv[0], eEn[1], eEn[0]});
	endtask

	task automatic tallyAndFinish;
		if (errorCnt == 0 && samplesChecked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// =================================================
	// Sequence and watchdog
	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		tReset;
		tFields;
		tRefuse;
		tRemap;
		tBurst;
		tallyAndFinish;
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		errorCnt++;
		tallyAndFinish;
	end
endmodule
